//--- hdl/lcd_driver_instruction_decoder.sv
// top: bus decoder, command registers and status of the bitmap lcd driver
//
// What this block does
// R1: a0, read and write strobes classify transfers
// R2: serial bytes arrive msb first
// R3: 1010111x turns display on or off
// R4: start line from 0101 and 0110 nibbles
// R5: page from 0100 bit0 and 1100 nibble
// R6: column from 0001 and 0000 nibbles
// R7: column increments, stops at 83h, page fixed
// R8: status: busy, segment, off, init, zeros
// R9: busy while executing or initialising
// R10: 1010000x segment reverse; status bit inverted
// R11: off flag reads one; init flag during init
// R12: 1010011x selects inverted display
// R13: 1010010x lights all; with off, power save
// R14: 70h enters sub table, 71h leaves
// R15: sub table stores four block settings
// R16: sub 40h applies blocks, partial mode on
// R17: sub inverse line count applied on execute
// R18: sub contrast applied only on a0h
// R19: 1011 prefix selects bias code
// R20: 001100 prefix selects booster multiple
// R21: 1110000x enters or leaves read-modify-write
// R22: e2h soft reset; 0010000x supply off/on
// R23: soft reset restores addresses, start line, contrast, blocks, bias, booster, inverse lines
// R24: pin reset also clears display and modes
// R25: host does dummy read after column set
// R26: table-select bit decides command meaning
`default_nettype none
module lcd_driver_instruction_decoder (
	// clock, reset, enable
	input wire logic CORE_CLK_IN,
	input wire logic RESET_IN,
	input wire logic CLK_EN_IN,
	// host bus
	input wire logic PAR_SEL_IN,
	input wire logic CS_N_IN,
	input wire logic CMD_DATA_SELECT_IN,
	input wire logic RD_N_IN,
	input wire logic WR_N_IN,
	input wire logic [7:0] DATA_IN,
	output logic [7:0] DATA_OUT,
	output logic DATA_OE_OUT,
	// serial link
	input wire logic SER_CLK_IN,
	input wire logic SER_DATA_IN,
	// display ram port
	input wire logic [7:0] RAM_RDATA_IN,
	output lcd_dec_pkg::ram_req_t RAM_REQ_OUT,
	// settings to the display core
	output lcd_dec_pkg::cfg_t CFG_OUT,
	output logic BUSY_OUT
);
	import lcd_dec_pkg::*;

	logic wr_n_prev_q, rd_n_prev_q;
	logic ser_valid;
	logic [7:0] ser_byte;
	logic par_wr, rd_ev, wr_ev, cmd_ev, dat_wr, dat_rd, stat_rd;
	logic [7:0] byte_w;
	logic sub_q;
	logic [7:0] col_q, col_save_q;
	logic [4:0] page_q;
	logic [7:0] read_latch_q;
	logic [7:0] busy_cnt_q;
	logic init_q;
	logic [5:0] inv_stage_q;
	logic [7:0] con_stage_q;
	logic [3:0] b1s_q, b2s_q;
	logic [4:0] b1c_q, b2c_q;
	logic m_cmd, s_cmd, soft_rst;

	function automatic logic [7:0] status_byte(input logic busy, input logic seg_rev,
		input logic on, input logic init);
		logic [7:0] s;
		s = 8'h00;
		s[ST_BUSY] = busy;
		s[ST_SEG] = !seg_rev;
		s[ST_OFF] = !on;
		s[ST_INIT] = init;
		return s;
	endfunction

	serial_byte_collector u_ser (
		.clk(CORE_CLK_IN),
		.rst(RESET_IN),
		.en(CLK_EN_IN),
		.sel_n(CS_N_IN | PAR_SEL_IN),
		.sclk(SER_CLK_IN),
		.sdata(SER_DATA_IN),
		.valid(ser_valid),
		.data(ser_byte)
	);

	// ==============================================================
	// transfer classification
	always_comb
	begin
		par_wr = CLK_EN_IN && PAR_SEL_IN && !CS_N_IN && !wr_n_prev_q && WR_N_IN;
		rd_ev = CLK_EN_IN && PAR_SEL_IN && !CS_N_IN && rd_n_prev_q && !RD_N_IN;
		wr_ev = par_wr || (CLK_EN_IN && ser_valid);
		byte_w = par_wr ? DATA_IN : ser_byte;
		cmd_ev = wr_ev && !CMD_DATA_SELECT_IN; // [R1]
		dat_wr = wr_ev && CMD_DATA_SELECT_IN; // [R1]
		stat_rd = rd_ev && !CMD_DATA_SELECT_IN; // [R1]
		dat_rd = rd_ev && CMD_DATA_SELECT_IN; // [R1]
		m_cmd = cmd_ev && !sub_q; // [R26]
		s_cmd = cmd_ev && sub_q; // [R26]
		soft_rst = m_cmd && byte_w == C_SOFT_RESET; // [R22]
	end

	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RESET_IN)
		begin
			wr_n_prev_q <= 1'b1;
			rd_n_prev_q <= 1'b1;
		end
		else if (CLK_EN_IN)
		begin
			wr_n_prev_q <= WR_N_IN;
			rd_n_prev_q <= RD_N_IN;
		end
	end

	// ==============================================================
	// table select
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RESET_IN)
			sub_q <= 1'b0; // [R26]
		else if (m_cmd && byte_w == C_SUB_ENTER)
			sub_q <= 1'b1; // [R14]
		else if (s_cmd && byte_w == C_SUB_EXIT)
			sub_q <= 1'b0; // [R14]
	end

	// ==============================================================
	// column and page addressing
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RESET_IN || soft_rst)
		begin
			col_q <= COL_RESET; // [R23]
			page_q <= PAGE_RESET; // [R23]
			col_save_q <= COL_RESET;
		end
		else if (m_cmd)
		begin
			if (byte_w[7:4] == P_COL_HI)
				col_q <= {byte_w[3:0], col_q[3:0]}; // [R6]
			else if (byte_w[7:4] == P_COL_LO)
				col_q <= {col_q[7:4], byte_w[3:0]}; // [R6]
			else if (byte_w[7:4] == P_PAGE_HI)
				page_q <= {byte_w[0], page_q[3:0]}; // [R5]
			else if (byte_w[7:4] == P_PAGE_LO)
				page_q <= {page_q[4], byte_w[3:0]}; // [R5]
			else if (byte_w == C_RMW_ON)
				col_save_q <= col_q; // [R21]
			else if (byte_w == C_RMW_END && CFG_OUT.rmw)
				col_q <= col_save_q; // [R21]
		end
		else if ((dat_wr || (dat_rd && !CFG_OUT.rmw)) && col_q != COL_LAST)
			col_q <= col_q + 8'h01; // [R7]
	end

	// ==============================================================
	// ram request and read latch; a read returns the byte fetched before
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RESET_IN)
		begin
			RAM_REQ_OUT <= '0;
			read_latch_q <= 8'h00;
		end
		else if (CLK_EN_IN)
		begin
			RAM_REQ_OUT.we <= dat_wr;
			RAM_REQ_OUT.page <= page_q;
			RAM_REQ_OUT.column <= col_q;
			if (dat_wr)
				RAM_REQ_OUT.wdata <= byte_w;
			if (dat_rd)
				read_latch_q <= RAM_RDATA_IN;
		end
	end

	// ==============================================================
	// host read drive
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RESET_IN)
		begin
			DATA_OUT <= 8'h00;
			DATA_OE_OUT <= 1'b0;
		end
		else if (CLK_EN_IN)
		begin
			if (stat_rd)
				DATA_OUT <= status_byte(BUSY_OUT, CFG_OUT.seg_reverse,
					CFG_OUT.display_on, init_q); // [R8] [R10] [R11]
			else if (dat_rd)
				DATA_OUT <= read_latch_q;
			if (rd_ev)
				DATA_OE_OUT <= 1'b1;
			else if (RD_N_IN || CS_N_IN)
				DATA_OE_OUT <= 1'b0;
		end
	end

	// ==============================================================
	// busy and initialisation timing
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RESET_IN)
		begin
			busy_cnt_q <= INIT_CNT; // [R9]
			init_q <= 1'b1; // [R11]
			BUSY_OUT <= 1'b1;
		end
		else if (CLK_EN_IN)
		begin
			if (soft_rst)
			begin
				busy_cnt_q <= INIT_CNT; // [R9]
				init_q <= 1'b1; // [R11]
				BUSY_OUT <= 1'b1;
			end
			else if (cmd_ev || dat_wr || dat_rd)
			begin
				busy_cnt_q <= EXEC_CNT; // [R9]
				BUSY_OUT <= 1'b1;
			end
			else if (busy_cnt_q > 8'h01)
				busy_cnt_q <= busy_cnt_q - 8'h01;
			else
			begin
				busy_cnt_q <= 8'h00;
				BUSY_OUT <= 1'b0;
				init_q <= 1'b0;
			end
		end
	end

	// ==============================================================
	// sub table staging registers
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RESET_IN || soft_rst)
		begin
			inv_stage_q <= INVLINE_RESET;
			con_stage_q <= CONTRAST_RESET;
			b1s_q <= BLK_START_RESET;
			b1c_q <= BLK_CNT_FULL;
			b2s_q <= BLK_START_RESET;
			b2c_q <= BLK_CNT_NONE;
		end
		else if (s_cmd)
		begin
			if (byte_w[7:4] == P_B1_START)
				b1s_q <= byte_w[3:0]; // [R15]
			else if (byte_w[7:5] == P_B1_CNT)
				b1c_q <= byte_w[4:0]; // [R15]
			else if (byte_w[7:4] == P_B2_START)
				b2s_q <= byte_w[3:0]; // [R15]
			else if (byte_w[7:5] == P_B2_CNT)
				b2c_q <= byte_w[4:0]; // [R15]
			else if (byte_w[7:4] == P_INV_HI)
				inv_stage_q[5:4] <= byte_w[1:0]; // [R17]
			else if (byte_w[7:4] == P_INV_LO)
				inv_stage_q[3:0] <= byte_w[3:0]; // [R17]
			else if (byte_w[7:4] == P_CON_HI)
				con_stage_q[7:4] <= byte_w[3:0]; // [R18]
			else if (byte_w[7:4] == P_CON_LO)
				con_stage_q[3:0] <= byte_w[3:0]; // [R18]
		end
	end

	// ==============================================================
	// applied settings
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RESET_IN)
		begin
			CFG_OUT <= '0; // [R24]
			CFG_OUT.contrast_level <= CONTRAST_RESET;
			CFG_OUT.bias <= BIAS_RESET;
			CFG_OUT.booster <= BOOST_RESET;
			CFG_OUT.b1_cnt <= BLK_CNT_FULL;
		end
		else if (soft_rst)
		begin
			CFG_OUT.start_line <= LINE_RESET; // [R23]
			CFG_OUT.contrast_level <= CONTRAST_RESET; // [R23]
			CFG_OUT.partial_on <= 1'b0; // [R23]
			CFG_OUT.b1_start <= BLK_START_RESET;
			CFG_OUT.b1_cnt <= BLK_CNT_FULL;
			CFG_OUT.b2_start <= BLK_START_RESET;
			CFG_OUT.b2_cnt <= BLK_CNT_NONE;
			CFG_OUT.bias <= BIAS_RESET; // [R23]
			CFG_OUT.booster <= BOOST_RESET; // [R23]
			CFG_OUT.inv_lines <= INVLINE_RESET; // [R23]
		end
		else if (m_cmd)
		begin
			if (byte_w[7:1] == C_DISP_ON[7:1])
				CFG_OUT.display_on <= byte_w[0]; // [R3]
			else if (byte_w[7:1] == C_INVERSE[7:1])
				CFG_OUT.inverse <= byte_w[0]; // [R12]
			else if (byte_w[7:1] == C_ALL_ON[7:1])
				CFG_OUT.all_on <= byte_w[0]; // [R13]
			else if (byte_w[7:1] == C_SEG_REV[7:1])
				CFG_OUT.seg_reverse <= byte_w[0]; // [R10]
			else if (byte_w[7:1] == C_RMW_ON[7:1])
				CFG_OUT.rmw <= !byte_w[0]; // [R21]
			else if (byte_w[7:1] == C_SUPPLY_ON[7:1])
				CFG_OUT.supply_on <= byte_w[0]; // [R22]
			else if (byte_w == C_DRIVE_LEVEL)
				CFG_OUT.drive_level_set <= 1'b1;
			else if (byte_w[7:4] == P_LINE_HI)
				CFG_OUT.start_line[7:4] <= byte_w[3:0]; // [R4]
			else if (byte_w[7:4] == P_LINE_LO)
				CFG_OUT.start_line[3:0] <= byte_w[3:0]; // [R4]
			else if (byte_w[7:4] == P_BIAS)
				CFG_OUT.bias <= byte_w[3:0]; // [R19]
			else if (byte_w[7:2] == P_BOOST)
				CFG_OUT.booster <= byte_w[1:0]; // [R20]
		end
		else if (s_cmd)
		begin
			if (byte_w == C_PARTIAL_GO)
			begin
				CFG_OUT.partial_on <= 1'b1; // [R16]
				CFG_OUT.b1_start <= b1s_q;
				CFG_OUT.b1_cnt <= b1c_q;
				CFG_OUT.b2_start <= b2s_q;
				CFG_OUT.b2_cnt <= b2c_q;
			end
			else if (byte_w == C_INVLINE_GO)
				CFG_OUT.inv_lines <= inv_stage_q; // [R17]
			else if (byte_w == C_CONTRAST_GO)
				CFG_OUT.contrast_level <= con_stage_q; // [R18]
		end
		else if (CLK_EN_IN)
			CFG_OUT.power_save <= !CFG_OUT.display_on && CFG_OUT.all_on; // [R13]
	end

	// ==============================================================
	// checks
	sequence s_soft_reset;
		CLK_EN_IN && soft_rst;
	endsequence
	sequence s_soft_done;
		CFG_OUT.contrast_level == CONTRAST_RESET && col_q == COL_RESET && init_q;
	endsequence

	property p_col_stop;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		dat_wr && col_q == COL_LAST |=> col_q == COL_LAST;
	endproperty
	a_col_stop: assert property (p_col_stop) else $error("column passed last"); // [R7]

	property p_col_inc;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		dat_wr && col_q < COL_LAST |=> col_q == $past(col_q) + 8'h01 && $stable(page_q);
	endproperty
	a_col_inc: assert property (p_col_inc) else $error("column did not step"); // [R7]

	property p_status;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		stat_rd |=> DATA_OUT[3:0] == 4'h0 && DATA_OUT[ST_SEG] == !CFG_OUT.seg_reverse
			&& DATA_OUT[ST_OFF] == !CFG_OUT.display_on && DATA_OE_OUT;
	endproperty
	a_status: assert property (p_status) else $error("status byte wrong"); // [R8]

	property p_disp_on;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		m_cmd && byte_w == C_DISP_ON |=> CFG_OUT.display_on;
	endproperty
	a_disp_on: assert property (p_disp_on) else $error("display not on"); // [R3]

	property p_sub_enter;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		m_cmd && byte_w == C_SUB_ENTER |=> sub_q ##0 $stable(CFG_OUT.inv_lines);
	endproperty
	a_sub_enter: assert property (p_sub_enter) else $error("sub table not entered"); // [R14]

	property p_con_stage;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		s_cmd && byte_w[7:4] == P_CON_HI |=> $stable(CFG_OUT.contrast_level);
	endproperty
	a_con_stage: assert property (p_con_stage) else $error("contrast applied early"); // [R18]

	property p_soft_reset;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		s_soft_reset |=> s_soft_done ##1 BUSY_OUT;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete"); // [R23]

	property p_busy;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		cmd_ev |=> BUSY_OUT [*2];
	endproperty
	a_busy: assert property (p_busy) else $error("busy not shown"); // [R9]

	property p_pin_reset;
		@(posedge CORE_CLK_IN)
		RESET_IN |=> !CFG_OUT.display_on && !CFG_OUT.seg_reverse && !CFG_OUT.rmw
			&& !CFG_OUT.supply_on && !sub_q && init_q;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset incomplete"); // [R24]
endmodule
`default_nettype wire

//--- hdl/serial_byte_collector.sv
// serial receiver: gathers eight bits msb first into one byte
`default_nettype none
module serial_byte_collector (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic sdata,
	output logic valid,
	output logic [7:0] data
);
	logic sclk_prev_q;
	logic [6:0] shift_q;
	logic [2:0] cnt_q;

	// ==============================================================
	// shift on each rising serial clock; deselect drops a partial byte
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sclk_prev_q <= 1'b0;
			shift_q <= 7'h00;
			cnt_q <= 3'h0;
			valid <= 1'b0;
			data <= 8'h00;
		end
		else if (en)
		begin
			sclk_prev_q <= sclk;
			valid <= 1'b0;
			if (sel_n)
				cnt_q <= 3'h0;
			else if (sclk && !sclk_prev_q)
			begin
				shift_q <= {shift_q[5:0], sdata}; // [R2]
				cnt_q <= cnt_q + 3'h1;
				if (cnt_q == 3'h7)
				begin
					data <= {shift_q, sdata}; // [R2]
					valid <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- include/lcd_dec_pkg.sv
// package: constants, command codes and carrier types of the lcd instruction decoder
`default_nettype none
package lcd_dec_pkg;
	// ==============================================================
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int INIT_TIME_NS = 1000;
	localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXEC_CYCLES = 2;
	localparam logic [7:0] INIT_CNT = 8'(INIT_CYCLES);
	localparam logic [7:0] EXEC_CNT = 8'(EXEC_CYCLES);

	// ==============================================================
	// address limits and reset values
	localparam logic [7:0] COL_LAST = 8'h83;
	localparam logic [7:0] COL_RESET = 8'h00;
	localparam logic [7:0] LINE_RESET = 8'h00;
	localparam logic [4:0] PAGE_RESET = 5'h00;
	localparam logic [7:0] CONTRAST_RESET = 8'hff;
	localparam logic [3:0] BIAS_RESET = 4'h8;
	localparam logic [1:0] BOOST_RESET = 2'h3;
	localparam logic [5:0] INVLINE_RESET = 6'h00;
	localparam logic [3:0] BLK_START_RESET = 4'h0;
	localparam logic [4:0] BLK_CNT_FULL = 5'h10;
	localparam logic [4:0] BLK_CNT_NONE = 5'h00;

	// ==============================================================
	// status byte field positions
	localparam int ST_BUSY = 7;
	localparam int ST_SEG = 6;
	localparam int ST_OFF = 5;
	localparam int ST_INIT = 4;

	// ==============================================================
	// full command codes
	localparam logic [7:0] C_DISP_OFF = 8'hae;
	localparam logic [7:0] C_DISP_ON = 8'haf;
	localparam logic [7:0] C_NORMAL = 8'ha6;
	localparam logic [7:0] C_INVERSE = 8'ha7;
	localparam logic [7:0] C_ALL_OFF = 8'ha4;
	localparam logic [7:0] C_ALL_ON = 8'ha5;
	localparam logic [7:0] C_SEG_NORM = 8'ha0;
	localparam logic [7:0] C_SEG_REV = 8'ha1;
	localparam logic [7:0] C_SUB_ENTER = 8'h70;
	localparam logic [7:0] C_SUB_EXIT = 8'h71;
	localparam logic [7:0] C_RMW_ON = 8'he0;
	localparam logic [7:0] C_RMW_END = 8'he1;
	localparam logic [7:0] C_SOFT_RESET = 8'he2;
	localparam logic [7:0] C_SUPPLY_OFF = 8'h20;
	localparam logic [7:0] C_SUPPLY_ON = 8'h21;
	localparam logic [7:0] C_DRIVE_LEVEL = 8'h22;
	localparam logic [7:0] C_PARTIAL_GO = 8'h40;
	localparam logic [7:0] C_INVLINE_GO = 8'h70;
	localparam logic [7:0] C_CONTRAST_GO = 8'ha0;

	// ==============================================================
	// nibble prefixes (upper four bits; booster upper six, block counts upper three)
	localparam logic [3:0] P_LINE_HI = 4'h5;
	localparam logic [3:0] P_LINE_LO = 4'h6;
	localparam logic [3:0] P_PAGE_HI = 4'h4;
	localparam logic [3:0] P_PAGE_LO = 4'hc;
	localparam logic [3:0] P_COL_HI = 4'h1;
	localparam logic [3:0] P_COL_LO = 4'h0;
	localparam logic [3:0] P_BIAS = 4'hb;
	localparam logic [5:0] P_BOOST = 6'h0c;
	localparam logic [3:0] P_B1_START = 4'h0;
	localparam logic [2:0] P_B1_CNT = 3'h1;
	localparam logic [3:0] P_B2_START = 4'hc;
	localparam logic [2:0] P_B2_CNT = 3'h7;
	localparam logic [3:0] P_INV_HI = 4'h5;
	localparam logic [3:0] P_INV_LO = 4'h6;
	localparam logic [3:0] P_CON_HI = 4'h8;
	localparam logic [3:0] P_CON_LO = 4'h9;

	// ==============================================================
	// carriers
	typedef struct packed {
		logic display_on;
		logic inverse;
		logic all_on;
		logic power_save;
		logic seg_reverse;
		logic rmw;
		logic supply_on;
		logic drive_level_set;
		logic partial_on;
		logic [7:0] start_line;
		logic [7:0] contrast_level;
		logic [5:0] inv_lines;
		logic [3:0] bias;
		logic [1:0] booster;
		logic [3:0] b1_start;
		logic [4:0] b1_cnt;
		logic [3:0] b2_start;
		logic [4:0] b2_cnt;
	} cfg_t;

	typedef struct packed {
		logic we;
		logic [4:0] page;
		logic [7:0] column;
		logic [7:0] wdata;
	} ram_req_t;
endpackage
`default_nettype wire

//--- tb/host_bus_model.sv
// host processor model: parallel and serial transfers towards the decoder
`default_nettype none
module host_bus_model (
	// clock and device state
	input wire logic clk_in,
	input wire logic busy_in,
	input wire logic [7:0] rdata_in,
	// bus towards the device
	output logic cs_n_out,
	output logic a0_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic [7:0] wdata_out,
	output logic sclk_out,
	output logic sdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cs_n_out = 1'b1;
		a0_out = 1'b0;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		wdata_out = 8'h00;
		sclk_out = 1'b0;
		sdata_out = 1'b0;
	end
	// =============================================================
	// no new instruction while the device reports busy
	task automatic wait_idle();
		while (busy_in !== 1'b0)
			@(posedge clk_in);
	endtask
	// strobe combinations pick the transfer kind
	task automatic wr(input logic cd, input logic [7:0] b);
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		a0_out <= cd;
		wdata_out <= b;
		wr_n_out <= 1'b0;
		@(posedge clk_in);
		wr_n_out <= 1'b1;
		@(posedge clk_in);
		cs_n_out <= 1'b1;
		wdata_out <= ~b;
		repeat (2) @(posedge clk_in);
		wait_idle();
	endtask
	task automatic rd(input logic cd, output logic [7:0] b);
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		a0_out <= cd;
		rd_n_out <= 1'b0;
		repeat (2) @(posedge clk_in);
		b = rdata_in;
		@(posedge clk_in);
		rd_n_out <= 1'b1;
		cs_n_out <= 1'b1;
		repeat (2) @(posedge clk_in);
	endtask
	// serial byte, clock stands low outside the frame
	task automatic ser(input logic cd, input logic [7:0] b);
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		a0_out <= cd;
		for (int i = 7; i >= 0; i--)
		begin
			@(posedge clk_in);
			sdata_out <= b[i];
			sclk_out <= 1'b0;
			@(posedge clk_in);
			sclk_out <= 1'b1;
		end
		@(posedge clk_in);
		sclk_out <= 1'b0;
		sdata_out <= ~b[0];
		repeat (2) @(posedge clk_in);
		cs_n_out <= 1'b1;
		@(posedge clk_in);
		wait_idle();
	endtask
endmodule
`default_nettype wire

//--- tb/test_lcd_driver_instruction_decoder.sv
// self-checking bench of the lcd instruction decoder
`default_nettype none
module test_lcd_driver_instruction_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	import lcd_dec_pkg::*;
	logic clk = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] ram_rdata = 8'h00;
	logic [7:0] oe_cnt = 8'h00;
	logic rst = 1'b1;
	logic par_sel = 1'b1;
	logic cs_n, a0, rd_n, wr_n, sclk, sdata, data_oe, busy;
	logic [7:0] dout, data_out, st, last_col, last_w;
	ram_req_t ram_req;
	cfg_t cfg;
	int miscompares = 0;
	int n_tests = 0;
	always #4 clk = ~clk;
	// =============================================================
	// device and host
	lcd_driver_instruction_decoder DUT (.CORE_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(clk_en),
		.PAR_SEL_IN(par_sel), .CS_N_IN(cs_n), .CMD_DATA_SELECT_IN(a0), .RD_N_IN(rd_n),
		.WR_N_IN(wr_n), .DATA_IN(dout), .DATA_OUT(data_out), .DATA_OE_OUT(data_oe),
		.SER_CLK_IN(sclk), .SER_DATA_IN(sdata), .RAM_RDATA_IN(ram_rdata), .RAM_REQ_OUT(ram_req),
		.CFG_OUT(cfg), .BUSY_OUT(busy));
	host_bus_model HOST (.clk_in(clk), .busy_in(busy), .rdata_in(data_out), .cs_n_out(cs_n),
		.a0_out(a0), .rd_n_out(rd_n), .wr_n_out(wr_n), .wdata_out(dout), .sclk_out(sclk),
		.sdata_out(sdata));
	// captures each ram write strobe, counts bus drive cycles, models ram contents
	always @(posedge clk)
	begin
		ram_rdata <= ram_req.column ^ 8'h5a;
		if (data_oe === 1'b1)
			oe_cnt <= oe_cnt + 8'h01;
		if (ram_req.we === 1'b1)
		begin
			last_col <= ram_req.column;
			last_w <= ram_req.wdata;
		end
	end
	// =============================================================
	// checking and ending
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		if (miscompares == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] b);
		HOST.wr(1'b0, b);
	endtask
	// =============================================================
	// scenarios
	task automatic t_reset();
		HOST.rd(1'b0, st);
		chk(st, 8'hf0);
		HOST.wait_idle();
		HOST.rd(1'b0, st);
		chk(st, 8'h60);
		chk(cfg.contrast_level, 8'hff);
		chk({4'h0, cfg.bias}, 8'h08);
		chk({6'h0, cfg.booster}, 8'h03);
		chk({3'h0, cfg.b1_cnt}, 8'h10);
		chk({3'h0, cfg.display_on, cfg.inverse, cfg.seg_reverse, cfg.rmw, cfg.supply_on},
			8'h00);
	endtask
	task automatic t_display();
		cmd(C_SEG_REV);
		cmd(C_DISP_ON);
		HOST.rd(1'b0, st);
		chk(st, 8'h00);
		cmd(C_INVERSE);
		chk({7'h0, cfg.inverse}, 8'h01);
		cmd(C_DISP_OFF);
		cmd(C_ALL_ON);
		repeat (2) @(posedge clk);
		chk({5'h0, cfg.display_on, cfg.all_on, cfg.power_save}, 8'h03);
		cmd(C_ALL_OFF);
		cmd(C_NORMAL);
		cmd(C_SEG_NORM);
		cmd(C_DISP_ON);
		chk({4'h0, cfg.all_on, cfg.inverse, cfg.seg_reverse, cfg.display_on}, 8'h01);
	endtask
	task automatic t_addr();
		cmd(8'h5b);
		cmd(8'h6f);
		chk(cfg.start_line, 8'hbf);
		cmd(8'h4f);
		cmd(8'hc7);
		cmd(8'h18);
		cmd(8'h02);
		chk({3'h0, ram_req.page}, 8'h17);
		chk(ram_req.column, 8'h82);
		HOST.wr(1'b1, 8'haa);
		chk(last_col, 8'h82);
		chk(last_w, 8'haa);
		HOST.wr(1'b1, 8'h55);
		HOST.wr(1'b1, 8'h66);
		chk(last_col, 8'h83);
		chk(ram_req.column, 8'h83);
		chk({3'h0, ram_req.page}, 8'h17);
	endtask
	task automatic t_read();
		logic [7:0] n0;
		cmd(8'h11);
		cmd(8'h04);
		HOST.rd(1'b1, st);
		n0 = oe_cnt;
		HOST.rd(1'b1, st);
		chk(st, 8'h14 ^ 8'h5a);
		chk(oe_cnt - n0, 8'h03);
		HOST.rd(1'b1, st);
		chk(st, 8'h15 ^ 8'h5a);
	endtask
	task automatic t_sub();
		cmd(C_SUB_ENTER);
		cmd(8'h8a);
		cmd(8'h95);
		chk(cfg.contrast_level, 8'hff);
		cmd(C_CONTRAST_GO);
		chk(cfg.contrast_level, 8'ha5);
		cmd(8'h81);
		chk(cfg.contrast_level, 8'ha5);
		cmd(8'h53);
		cmd(8'h6e);
		chk({2'h0, cfg.inv_lines}, 8'h00);
		cmd(C_INVLINE_GO);
		chk({2'h0, cfg.inv_lines}, 8'h3e);
		cmd(8'h03);
		cmd(8'h22);
		cmd(8'hc4);
		cmd(8'he5);
		chk({7'h0, cfg.partial_on}, 8'h00);
		cmd(C_PARTIAL_GO);
		chk({7'h0, cfg.partial_on}, 8'h01);
		chk({cfg.b1_start, cfg.b2_start}, 8'h34);
		chk({3'h0, cfg.b1_cnt}, 8'h02);
		chk({3'h0, cfg.b2_cnt}, 8'h05);
		chk(cfg.start_line, 8'hbf);
		cmd(C_SUB_EXIT);
		cmd(C_SEG_REV);
		chk({7'h0, cfg.seg_reverse}, 8'h01);
		cmd(8'ha0);
		chk({7'h0, cfg.seg_reverse}, 8'h00);
		chk(cfg.contrast_level, 8'ha5);
	endtask
	task automatic t_misc();
		cmd(8'hb3);
		chk({4'h0, cfg.bias}, 8'h03);
		cmd(8'h31);
		chk({6'h0, cfg.booster}, 8'h01);
		cmd(C_RMW_ON);
		chk({7'h0, cfg.rmw}, 8'h01);
		cmd(C_RMW_END);
		cmd(C_SUPPLY_ON);
		chk({6'h0, cfg.rmw, cfg.supply_on}, 8'h01);
		cmd(C_DRIVE_LEVEL);
		chk({7'h0, cfg.drive_level_set}, 8'h01);
		cmd(C_SOFT_RESET);
		chk({cfg.contrast_level}, 8'hff);
		chk({cfg.bias, 2'h0, cfg.booster}, 8'h83);
		chk({cfg.start_line[5:0], cfg.inv_lines[1:0]}, 8'h00);
		chk({ram_req.page, 3'h0}, 8'h00);
		chk(ram_req.column, 8'h00);
		chk({6'h0, cfg.display_on, cfg.supply_on}, 8'h03);
		cmd(C_SUPPLY_OFF);
		chk({7'h0, cfg.supply_on}, 8'h00);
	endtask
	task automatic t_pin_reset();
		clk_en <= 1'b0;
		cmd(C_DISP_OFF);
		chk({7'h0, cfg.display_on}, 8'h01);
		clk_en <= 1'b1;
		cmd(C_SEG_REV);
		cmd(C_INVERSE);
		cmd(C_RMW_ON);
		cmd(C_SUPPLY_ON);
		cmd(C_SUB_ENTER);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		HOST.wait_idle();
		chk({3'h0, cfg.display_on, cfg.inverse, cfg.seg_reverse, cfg.rmw, cfg.supply_on},
			8'h00);
		cmd(C_SEG_REV);
		chk({7'h0, cfg.seg_reverse}, 8'h01);
	endtask
	task automatic t_serial();
		par_sel <= 1'b0;
		HOST.ser(1'b0, 8'hb5);
		chk({4'h0, cfg.bias}, 8'h05);
		HOST.ser(1'b1, 8'h3c);
		chk(last_w, 8'h3c);
		par_sel <= 1'b1;
	endtask
	// =============================================================
	// main sequence and watchdog
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_display();
		t_addr();
		t_read();
		t_sub();
		t_misc();
		t_pin_reset();
		t_serial();
		stop_test();
	end
	initial
	begin
		#400000;
		miscompares++;
		stop_test();
	end
endmodule
`default_nettype wire
